// ===== rtl/sllp_pkg.sv
// shared constants and types of the serial latch load port
package sllp_pkg;
    // shift word layout
    localparam int WORD_W = 22;
    localparam int CTRL_HI = 1;
    localparam int CTRL_LO = 0;
    localparam int PRESC_BIT = 20;
    // test output selector field inside the IF reference divider latch
    localparam int MUX_HI = 17;
    localparam int MUX_LO = 16;
    localparam logic [WORD_W-1:0] WORD_RST = 22'h000000;
    // destination latch, in control bit order
    typedef enum logic [1:0]
    {
        LATCH_IF_REF,
        LATCH_IF_FB,
        LATCH_RF_REF,
        LATCH_RF_FB
    } sllp_latch_type;
    // test output sources
    localparam logic [1:0] MUX_IF_LOCK = 2'h0;
    localparam logic [1:0] MUX_RF_LOCK = 2'h1;
    localparam logic [1:0] MUX_RF_DIV = 2'h2;
    localparam logic [1:0] MUX_REF_DIV = 2'h3;
    // external status inputs, one bit each
    localparam int STAT_W = 4;
    localparam int STAT_IF_LOCK = 0;
    localparam int STAT_RF_LOCK = 1;
    localparam int STAT_RF_DIV = 2;
    localparam int STAT_REF_DIV = 3;
endpackage

// ===== rtl/sllp_word_if.sv
// carries the shift register word from the serial clock domain
`timescale 1ns/10ps
interface sllp_word_if;
    logic [sllp_pkg::WORD_W-1:0] word;
    modport src
    (
        output word
    );
    modport dst
    (
        input word
    );
endinterface

// ===== rtl/sllp_sync.sv
// two flip-flop level synchroniser, one per bit
`timescale 1ns/10ps
module sllp_sync
#(
    parameter int W = 1
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] din_i,
    output logic [W-1:0] dout_o
);
    logic [W-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_reg <= '0;
            dout_o <= '0;
        end
        else
        begin
            meta_reg <= din_i;
            dout_o <= meta_reg;
        end
    end
endmodule

// ===== rtl/sllp_shift.sv
// serial shift register on the link clock
`timescale 1ns/10ps
module sllp_shift
(
    input wire logic sclk_i,
    input wire logic rst_n_i,
    input wire logic sdata_i,
    sllp_word_if.src word_if
);
    import sllp_pkg::*;

    // msb first: earlier bits walk up toward the top of the word
    always_ff @(posedge sclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            word_if.word <= WORD_RST;
        else
            word_if.word <= {word_if.word[WORD_W-2:0], sdata_i};
    end

    shift_in_a: assert property (@(posedge sclk_i) disable iff (!rst_n_i)
        ##1 (word_if.word[0] == $past(sdata_i)))
        else $error("serial bit not captured at word bit zero");

    msb_first_a: assert property (@(posedge sclk_i) disable iff (!rst_n_i)
        ##1 (word_if.word[WORD_W-1:1] == $past(word_if.word[WORD_W-2:0])))
        else $error("earlier bits did not move toward the msb");
endmodule

// ===== rtl/sllp_top.sv
// serial latch load port: shift register, four latches, test output mux
`timescale 1ns/10ps
module sllp_top
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic sdata_i,
    input wire logic load_strobe_i,
    input wire logic if_lock_i,
    input wire logic rf_lock_i,
    input wire logic rf_div_i,
    input wire logic ref_div_i,
    output logic test_output_mux_o,
    output logic [sllp_pkg::WORD_W-1:0] if_ref_latch_o,
    output logic [sllp_pkg::WORD_W-1:0] if_fb_latch_o,
    output logic [sllp_pkg::WORD_W-1:0] rf_ref_latch_o,
    output logic [sllp_pkg::WORD_W-1:0] rf_fb_latch_o,
    output logic if_presc_16_o,
    output logic rf_presc_32_o,
    output logic load_done_o
);
    import sllp_pkg::*;

    // pick the test output source for a selector code
    function automatic logic sllp_mux_pick
    (
        input logic [1:0] sel,
        input logic [STAT_W-1:0] stat
    );
        logic pick;
        pick = 1'b0;
        unique case (sel)
            MUX_IF_LOCK: pick = stat[STAT_IF_LOCK];
            MUX_RF_LOCK: pick = stat[STAT_RF_LOCK];
            MUX_RF_DIV: pick = stat[STAT_RF_DIV];
            MUX_REF_DIV: pick = stat[STAT_REF_DIV];
        endcase
        return pick;
    endfunction

    sllp_word_if word_if ();
    logic load_sync;
    logic load_d_reg;
    logic load_rise;
    logic [STAT_W-1:0] stat_raw;
    logic [STAT_W-1:0] stat_sync;
    logic [WORD_W-1:0] word_next;
    sllp_latch_type dest;

    // serial side: runs on the link clock only
    sllp_shift u_shift
    (
        .sclk_i(sclk_i),
        .rst_n_i(rst_n_i),
        .sdata_i(sdata_i),
        .word_if(word_if.src)
    );

    // load strobe is a pin, so it is synchronised before edge detection
    sllp_sync #(.W(1)) u_load_sync
    (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .din_i(load_strobe_i),
        .dout_o(load_sync)
    );

    assign stat_raw[STAT_IF_LOCK] = if_lock_i;
    assign stat_raw[STAT_RF_LOCK] = rf_lock_i;
    assign stat_raw[STAT_RF_DIV] = rf_div_i;
    assign stat_raw[STAT_REF_DIV] = ref_div_i;

    // status sources come from other domains as well
    sllp_sync #(.W(STAT_W)) u_stat_sync
    (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .din_i(stat_raw),
        .dout_o(stat_sync)
    );

    // strobe edge detector on the synchronised level
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            load_d_reg <= 1'b0;
        else
            load_d_reg <= load_sync;
    end

    assign load_rise = load_sync & ~load_d_reg;

    // the word is quasi-static here: the host stops the serial clock
    // before raising the strobe, so no gray code is needed for it;
    // the two-flop delay on the strobe is what gives the word time to
    // settle. limitation: a host that clocks during the strobe can
    // load a torn word, which nothing here is able to detect
    assign word_next = word_if.word;
    assign dest = sllp_latch_type'(word_next[CTRL_HI:CTRL_LO]);

    // one latch per destination; the others keep their value
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            if_ref_latch_o <= WORD_RST;
            if_fb_latch_o <= WORD_RST;
            rf_ref_latch_o <= WORD_RST;
            rf_fb_latch_o <= WORD_RST;
        end
        else if (load_rise)
        begin
            unique case (dest)
                LATCH_IF_REF: if_ref_latch_o <= word_next;
                LATCH_IF_FB: if_fb_latch_o <= word_next;
                LATCH_RF_REF: rf_ref_latch_o <= word_next;
                LATCH_RF_FB: rf_fb_latch_o <= word_next;
            endcase
        end
    end

    // prescaler ratio bits come straight from the feedback latches
    assign if_presc_16_o = if_fb_latch_o[PRESC_BIT];
    assign rf_presc_32_o = rf_fb_latch_o[PRESC_BIT];

    // one-cycle pulse marking that a latch took a new word
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            load_done_o <= 1'b0;
        else
            load_done_o <= load_rise;
    end

    // test output, registered so the pin never glitches on a select change
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            test_output_mux_o <= 1'b0;
        else
            test_output_mux_o <= sllp_mux_pick(
                if_ref_latch_o[MUX_HI:MUX_LO], stat_sync);
    end

    // checks

    if_ref_load_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        load_rise && (word_next[CTRL_HI:CTRL_LO] == 2'h0)
        |=> (if_ref_latch_o == $past(word_next)) && $stable(if_fb_latch_o)
            && $stable(rf_ref_latch_o) && $stable(rf_fb_latch_o))
        else $error("code 00 did not load only the if reference latch");

    if_fb_load_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        load_rise && (word_next[CTRL_HI:CTRL_LO] == 2'h1)
        |=> (if_fb_latch_o == $past(word_next)) && $stable(if_ref_latch_o)
            && $stable(rf_ref_latch_o) && $stable(rf_fb_latch_o))
        else $error("code 01 did not load only the if feedback latch");

    rf_ref_load_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        load_rise && (word_next[CTRL_HI:CTRL_LO] == 2'h2)
        |=> (rf_ref_latch_o == $past(word_next)) && $stable(if_ref_latch_o)
            && $stable(if_fb_latch_o) && $stable(rf_fb_latch_o))
        else $error("code 10 did not load only the rf reference latch");

    rf_fb_load_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        load_rise && (word_next[CTRL_HI:CTRL_LO] == 2'h3)
        |=> (rf_fb_latch_o == $past(word_next)) && $stable(if_ref_latch_o)
            && $stable(if_fb_latch_o) && $stable(rf_ref_latch_o))
        else $error("code 11 did not load only the rf feedback latch");

    latch_hold_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        !load_sync |=> $stable(if_ref_latch_o) && $stable(if_fb_latch_o)
            && $stable(rf_ref_latch_o) && $stable(rf_fb_latch_o))
        else $error("a latch changed while the load strobe was low");

    strobe_edge_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        $rose(load_sync) |=> load_done_o ##1 !load_done_o)
        else $error("strobe rise did not give a single load pulse");

    if_presc_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        load_rise && (dest == LATCH_IF_FB)
        |=> if_presc_16_o == $past(word_next[PRESC_BIT]))
        else $error("if prescaler ratio does not follow bit 20");

    rf_presc_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        load_rise && (dest == LATCH_RF_FB)
        |=> rf_presc_32_o == $past(word_next[PRESC_BIT]))
        else $error("rf prescaler ratio does not follow bit 20");

    test_mux_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        ##1 test_output_mux_o == sllp_mux_pick(
            $past(if_ref_latch_o[MUX_HI:MUX_LO]), $past(stat_sync)))
        else $error("test output does not show the selected source");

    // a strobe held high must not load a second time
    strobe_held_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        load_sync && load_d_reg |=> $stable(if_ref_latch_o)
            && $stable(if_fb_latch_o) && $stable(rf_ref_latch_o)
            && $stable(rf_fb_latch_o))
        else $error("a strobe held high loaded a latch again");

    // exactly one destination per load, never two at once
    one_latch_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        $onehot0({$changed(if_ref_latch_o), $changed(if_fb_latch_o),
            $changed(rf_ref_latch_o), $changed(rf_fb_latch_o)}))
        else $error("more than one latch changed in one cycle");

    // latches only move in the cycle after a strobe rise
    change_cause_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        $changed(if_ref_latch_o) || $changed(if_fb_latch_o)
            || $changed(rf_ref_latch_o) || $changed(rf_fb_latch_o)
        |-> $past(load_rise))
        else $error("a latch changed without a strobe rise");

    // the load pulse never lasts two cycles
    done_pulse_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        load_done_o |=> !load_done_o)
        else $error("load pulse lasted more than one cycle");

    // a load pulse means some latch now holds the shifted word
    done_word_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        load_done_o |-> (if_ref_latch_o == $past(word_next))
            || (if_fb_latch_o == $past(word_next))
            || (rf_ref_latch_o == $past(word_next))
            || (rf_fb_latch_o == $past(word_next)))
        else $error("load pulse without a latch holding the word");

    // each latch only ever holds its own control code, or reset
    if_ref_code_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        if_ref_latch_o[CTRL_HI:CTRL_LO] == LATCH_IF_REF)
        else $error("if reference latch holds a foreign code");

    if_fb_code_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        (if_fb_latch_o[CTRL_HI:CTRL_LO] == LATCH_IF_FB)
            || (if_fb_latch_o == WORD_RST))
        else $error("if feedback latch holds a foreign code");

    rf_ref_code_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        (rf_ref_latch_o[CTRL_HI:CTRL_LO] == LATCH_RF_REF)
            || (rf_ref_latch_o == WORD_RST))
        else $error("rf reference latch holds a foreign code");

    rf_fb_code_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        (rf_fb_latch_o[CTRL_HI:CTRL_LO] == LATCH_RF_FB)
            || (rf_fb_latch_o == WORD_RST))
        else $error("rf feedback latch holds a foreign code");

    // ratio outputs only move when a word lands
    presc_hold_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        !load_rise |=> $stable(if_presc_16_o) && $stable(rf_presc_32_o))
        else $error("a prescaler ratio moved without a load");

    // with select and sources steady the pin must not toggle
    mux_steady_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        $stable(if_ref_latch_o[MUX_HI:MUX_LO]) && $stable(stat_sync)
        |=> $stable(test_output_mux_o))
        else $error("test output moved with select and sources steady");

    // the strobe reaches the edge detector two clocks after the pin
    sync_delay_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        $rose(load_sync) |-> $past(load_strobe_i, 2))
        else $error("strobe crossed with the wrong latency");

    // no pulse without a strobe rise the cycle before
    done_cause_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        !load_rise |=> !load_done_o)
        else $error("load pulse without a strobe rise");

    // a pulse needs the strobe seen low before it was seen high
    rise_low_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        $rose(load_done_o) |-> !$past(load_sync, 2))
        else $error("load pulse without a low strobe before it");
endmodule

// ===== verification/sllp_host.sv
// host model driving the three-wire programming port
`timescale 1ns/10ps
module sllp_host
(
    output logic sclk_o,
    output logic sdata_o,
    output logic load_strobe_o
);
    initial
    begin
        sclk_o = 1'b0;
        sdata_o = 1'b0;
        load_strobe_o = 1'b0;
    end
    // shift n bits msb first; the clock stays low between frames
    task automatic send_word(input logic [31:0] w, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            sdata_o = w[i];
            #16 sclk_o = 1'b1;
            #16 sclk_o = 1'b0;
        end
        // hold time over: the line no longer shows the last bit
        #10 sdata_o = ~sdata_o;
    endtask
    // one strobe pulse, several system clocks wide
    task automatic strobe(input int hi_ns);
        load_strobe_o = 1'b1;
        #(hi_ns) load_strobe_o = 1'b0;
    endtask
endmodule

// ===== verification/tb_top.sv
// self-checking bench for the serial latch load port
`timescale 1ns/10ps
module tb_top;
    import sllp_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b1;
    logic sclk, sdata, strb, mux_o, if_p, rf_p, done;
    logic [STAT_W-1:0] stat = '0;
    logic [WORD_W-1:0] lat_o [4];
    logic [WORD_W-1:0] lat_m [4];
    logic [4*WORD_W-1:0] exp_q [$];
    logic [4*WORD_W-1:0] e;
    int miscompares = 0;
    int checked = 0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    sllp_host u_host (.sclk_o(sclk), .sdata_o(sdata), .load_strobe_o(strb));
    sllp_top u_dut
    (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sclk_i(sclk),
        .sdata_i(sdata), .load_strobe_i(strb),
        .if_lock_i(stat[STAT_IF_LOCK]), .rf_lock_i(stat[STAT_RF_LOCK]),
        .rf_div_i(stat[STAT_RF_DIV]), .ref_div_i(stat[STAT_REF_DIV]),
        .test_output_mux_o(mux_o), .if_ref_latch_o(lat_o[0]),
        .if_fb_latch_o(lat_o[1]), .rf_ref_latch_o(lat_o[2]),
        .rf_fb_latch_o(lat_o[3]), .if_presc_16_o(if_p),
        .rf_presc_32_o(rf_p), .load_done_o(done)
    );
    task automatic check(input string nm, input logic [WORD_W-1:0] s, x);
        checked++;
        if (s !== x)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic complete_run();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // send a word with extra leading bits, strobe, wait for the monitor
    task automatic load(input logic [WORD_W-1:0] w, input int extra);
        logic [31:0] rnd;
        int n;
        rnd = $urandom;
        u_host.send_word({rnd[9:0], w}, WORD_W + extra);
        lat_m[w[CTRL_HI:CTRL_LO]] = w;
        exp_q.push_back({lat_m[3], lat_m[2], lat_m[1], lat_m[0]});
        @(negedge clk_sys_i);
        u_host.strobe(40);
        n = 0;
        while (exp_q.size() != 0 && n < 40)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        if (exp_q.size() != 0)
        begin
            check("load_wait", 22'h1, 22'h0);
            complete_run();
        end
    endtask
    // monitor: each load pulse retires the oldest note
    always @(negedge clk_sys_i)
        if (done === 1'b1 && exp_q.size() == 0)
            check("load_done", 22'h1, 22'h0);
        else if (done === 1'b1)
        begin
            e = exp_q.pop_front();
            for (int k = 0; k < 4; k++)
                check("latch", lat_o[k], e[k*WORD_W +: WORD_W]);
            check("if_presc", {21'h0, if_p}, {21'h0, e[WORD_W+PRESC_BIT]});
            check("rf_presc", {21'h0, rf_p}, {21'h0, e[3*WORD_W+PRESC_BIT]});
        end
    initial
    begin
        logic [WORD_W-1:0] w;
        void'($urandom(32'h2082d941));
        for (int k = 0; k < 4; k++)
            lat_m[k] = WORD_RST;
        // a real falling edge, so the link side resets with no clock
        #1 rst_n_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        // every destination code, both prescaler ratios, overlong frames
        for (int r = 0; r < 8; r++)
        begin
            w = WORD_W'($urandom);
            w[PRESC_BIT] = r[2]; // host picks the ratio
            w[CTRL_HI:CTRL_LO] = r[1:0];
            load(w, r);
        end
        $display("test latch_load done");
        // shifting without a strobe must leave every latch alone
        u_host.send_word($urandom, 32);
        repeat (10) @(negedge clk_sys_i);
        for (int k = 0; k < 4; k++)
            check("hold", lat_o[k], lat_m[k]);
        $display("test latch_hold done");
        // each test output source, with changing status levels
        for (int s = 0; s < 4; s++)
        begin
            w = WORD_W'($urandom);
            w[MUX_HI:MUX_LO] = s[1:0];
            w[CTRL_HI:CTRL_LO] = LATCH_IF_REF;
            load(w, 0);
            repeat (4)
            begin
                stat = STAT_W'($urandom);
                repeat (4) @(negedge clk_sys_i);
                check("mux", {21'h0, mux_o}, {21'h0, stat[s]});
            end
        end
        $display("test output_mux done");
        complete_run();
    end
endmodule
